// ===== logic/ewg_wait_gen.sv
// Wait-state generator: range registers, count selection and bus cycle stretching.
`timescale 1ns/10ps
module ewg_wait_gen
	import ewg_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic        acc_start,
	input  wire logic [1:0]  acc_space,
	input  wire logic [15:0] acc_addr,
	input  wire logic        ready,
	output logic             acc_done,
	output logic             acc_busy,
	output logic             wait_clk_on
);
	// ---------------------------------------------------------------
	// Registers and helpers
	// ---------------------------------------------------------------
	ewg_state_t  state_reg;
	logic [15:0] wait_state_ranges_reg;
	logic        wait_double_bit_reg;
	logic [3:0]  count_reg;
	logic [3:0]  waits_next;
	logic        all_zero;
	logic        ready_s1_reg;
	logic        ready_s2_reg;
	logic        ready_s3_reg;
	logic        ready_reg;

	// Pulls one 3-bit base count out of the range register.
	function automatic logic [2:0] ewg_field(input logic [15:0] r, input int lsb);
		ewg_field = r[lsb +: 3];
	endfunction : ewg_field

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	// Range register loads seven waits everywhere at reset.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wait_state_ranges_reg <= EWG_WSR_RESET;
		end else if (reg_wr && reg_addr == EWG_WSR_ADDR) begin
			wait_state_ranges_reg <= reg_wdata;
		end
	end

	// Only the double bit is stored; upper bits are not kept so they can never read back.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wait_double_bit_reg <= EWG_SCR_RESET[EWG_DBL_BIT];
		end else if (reg_wr && reg_addr == EWG_SCR_ADDR) begin
			wait_double_bit_reg <= reg_wdata[EWG_DBL_BIT];
		end
	end

	// Registered read data; unmapped addresses read zero.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == EWG_WSR_ADDR) begin
				reg_rdata <= wait_state_ranges_reg;
			end else if (reg_addr == EWG_SCR_ADDR) begin
				reg_rdata <= {15'h0, wait_double_bit_reg};
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// ---------------------------------------------------------------
	// Count selection
	// ---------------------------------------------------------------
	// Picks the base count for the access's space and address, then scales it.
	always_comb begin
		logic [2:0] base;
		base = 3'h0;
		case (acc_space)
			EWG_SPACE_IO: begin
				base = ewg_field(wait_state_ranges_reg, EWG_IO_LSB);
			end
			EWG_SPACE_DATA: begin
				if (acc_addr[EWG_HALF_BIT]) begin
					base = ewg_field(wait_state_ranges_reg, EWG_DHI_LSB);
				end else begin
					base = ewg_field(wait_state_ranges_reg, EWG_DLO_LSB);
				end
			end
			default: begin
				if (!wait_state_ranges_reg[EWG_SEL_BIT] && acc_addr[EWG_HALF_BIT]) begin
					base = ewg_field(wait_state_ranges_reg, EWG_PHI_LSB);
				end else begin
					base = ewg_field(wait_state_ranges_reg, EWG_PLO_LSB);
				end
			end
		endcase
		// Doubling of seven gives fourteen, the largest software count.
		waits_next = wait_double_bit_reg ? {base, 1'b0} : {1'b0, base};
	end

	// With every field at zero no access can need counting.
	assign all_zero = (wait_state_ranges_reg[14:0] == 15'h0);

	// Clock enable to the counter; held low when nothing can wait, to save power.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wait_clk_on <= 1'b1;
		end else begin
			wait_clk_on <= !all_zero;
		end
	end

	// ---------------------------------------------------------------
	// Ready synchroniser
	// ---------------------------------------------------------------
	// Ready comes from a pin; the first stage feeds only the second.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ready_s1_reg <= 1'b1;
			ready_s2_reg <= 1'b1;
			ready_s3_reg <= 1'b1;
			ready_reg    <= 1'b1;
		end else begin
			ready_s1_reg <= ready;
			ready_s2_reg <= ready_s1_reg;
			ready_s3_reg <= ready_s2_reg;
			if (ready_s2_reg == ready_s3_reg) begin
				ready_reg <= ready_s3_reg;
			end
		end
	end

	// ---------------------------------------------------------------
	// Bus cycle sequencer
	// ---------------------------------------------------------------
	// Counts waits down, then holds the cycle until ready is seen high.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= EWG_IDLE;
			count_reg <= 4'h0;
			acc_done  <= 1'b0;
			acc_busy  <= 1'b0;
		end else begin
			acc_done <= 1'b0;
			case (state_reg)
				EWG_IDLE: begin
					if (acc_start) begin
						acc_busy  <= 1'b1;
						count_reg <= waits_next;
						// The enable lags a range write by a cycle, so only the count decides.
						if (waits_next != 4'h0) begin
							state_reg <= EWG_WAIT;
						end else begin
							state_reg <= EWG_RDY;
						end
					end
				end
				EWG_WAIT: begin
					if (count_reg <= 4'h1) begin
						count_reg <= 4'h0;
						state_reg <= EWG_RDY;
					end else begin
						count_reg <= count_reg - 4'h1;
					end
				end
				EWG_RDY: begin
					if (ready_reg) begin
						acc_done  <= 1'b1;
						acc_busy  <= 1'b0;
						state_reg <= EWG_IDLE;
					end
				end
				default: begin
					state_reg <= EWG_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_start_zero;
		state_reg == EWG_IDLE && acc_start && waits_next == 4'h0 && ready_reg;
	endsequence

	// A start that the idle sequencer takes, whatever its count.
	sequence s_start_taken;
		state_reg == EWG_IDLE && acc_start;
	endsequence

	// A countdown cycle with more than one wait still to run.
	sequence s_count_step;
		state_reg == EWG_WAIT && count_reg > 4'h1;
	endsequence

	// The last countdown cycle of a stretched access.
	sequence s_count_last;
		state_reg == EWG_WAIT && count_reg <= 4'h1;
	endsequence

	// Waiting on ready with the synchronised level still low.
	sequence s_rdy_held;
		state_reg == EWG_RDY && !ready_reg;
	endsequence

	AST_COUNT_MAX: assert property (@(posedge mclk) disable iff (rst)
		count_reg <= EWG_MAX_WAITS)
		else $error("Wait count above fourteen.");

	AST_READY_HOLD: assert property (@(posedge mclk) disable iff (rst)
		(state_reg == EWG_RDY && !ready_reg) |=> !acc_done)
		else $error("Cycle ended while ready low.");

	AST_CLK_GATE: assert property (@(posedge mclk) disable iff (rst)
		all_zero |=> !wait_clk_on)
		else $error("Clock enable not gated with all-zero ranges.");

	AST_DOUBLE: assert property (@(posedge mclk) disable iff (rst)
		wait_double_bit_reg |-> !waits_next[0])
		else $error("Doubled count is odd.");

	AST_SCR_READ: assert property (@(posedge mclk) disable iff (rst)
		(reg_rd && reg_addr == EWG_SCR_ADDR) |=> reg_rdata[15:1] == 15'h0)
		else $error("Reserved scale bits read nonzero.");

	AST_WSR_WRITE: assert property (@(posedge mclk) disable iff (rst)
		(reg_wr && reg_addr == EWG_WSR_ADDR) |=> wait_state_ranges_reg == $past(reg_wdata))
		else $error("Range register did not take write.");

	AST_IO_SEL: assert property (@(posedge mclk) disable iff (rst)
		(acc_space == EWG_SPACE_IO && !wait_double_bit_reg)
		|-> waits_next == {1'b0, wait_state_ranges_reg[14:12]})
		else $error("I/O count not from I/O field.");

	AST_PHI_OFF: assert property (@(posedge mclk) disable iff (rst)
		(acc_space == EWG_SPACE_PROG && wait_state_ranges_reg[15] && !wait_double_bit_reg)
		|-> waits_next == {1'b0, wait_state_ranges_reg[2:0]})
		else $error("Range select one did not use low program field.");

	AST_ZERO_FAST: assert property (@(posedge mclk) disable iff (rst)
		s_start_zero |=> ##1 acc_done)
		else $error("Zero-wait access did not end in two cycles.");

	// Step-by-step checks follow one access from the taking edge to its done pulse.
	AST_START_LOAD: assert property (@(posedge mclk) disable iff (rst)
		s_start_taken |=> (acc_busy && count_reg == $past(waits_next)))
		else $error("Taken start did not load the scaled count.");

	AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (rst)
		s_count_step |=> (state_reg == EWG_WAIT && count_reg == $past(count_reg) - 4'h1))
		else $error("Wait count did not step down by one.");

	AST_COUNT_END: assert property (@(posedge mclk) disable iff (rst)
		s_count_last |=> state_reg == EWG_RDY)
		else $error("Last wait did not hand over to the ready check.");

	AST_RDY_STAY: assert property (@(posedge mclk) disable iff (rst)
		s_rdy_held |=> (state_reg == EWG_RDY && acc_busy))
		else $error("Cycle left the ready check while ready low.");

	AST_DONE_READY: assert property (@(posedge mclk) disable iff (rst)
		acc_done |-> ($past(ready_reg) && $past(state_reg) == EWG_RDY))
		else $error("Done without ready seen high in the ready check.");

	AST_BUSY_LEVEL: assert property (@(posedge mclk) disable iff (rst)
		acc_busy == (state_reg != EWG_IDLE))
		else $error("Busy does not match the sequencer state.");

	AST_GATE_ON: assert property (@(posedge mclk) disable iff (rst)
		!all_zero |=> wait_clk_on)
		else $error("Clock enable low with a nonzero range.");

	AST_SCR_WRITE: assert property (@(posedge mclk) disable iff (rst)
		(reg_wr && reg_addr == EWG_SCR_ADDR && reg_wdata[EWG_DBL_BIT])
		|=> wait_double_bit_reg)
		else $error("Double bit did not take a write of one.");

	AST_RDATA_WSR: assert property (@(posedge mclk) disable iff (rst)
		(reg_rd && reg_addr == EWG_WSR_ADDR)
		|=> reg_rdata == $past(wait_state_ranges_reg))
		else $error("Range register read back wrong.");

	AST_DHI_SEL: assert property (@(posedge mclk) disable iff (rst)
		(acc_space == EWG_SPACE_DATA && acc_addr[15] && !wait_double_bit_reg)
		|-> waits_next == {1'b0, wait_state_ranges_reg[11:9]})
		else $error("Upper data count not from its field.");

	AST_DLO_SEL: assert property (@(posedge mclk) disable iff (rst)
		(acc_space == EWG_SPACE_DATA && !acc_addr[15] && !wait_double_bit_reg)
		|-> waits_next == {1'b0, wait_state_ranges_reg[8:6]})
		else $error("Lower data count not from its field.");

	AST_PHI_SEL: assert property (@(posedge mclk) disable iff (rst)
		(acc_space == EWG_SPACE_PROG && !wait_state_ranges_reg[15] && acc_addr[15]
		&& !wait_double_bit_reg)
		|-> waits_next == {1'b0, wait_state_ranges_reg[5:3]})
		else $error("Upper program count not from its field.");

	AST_PLO_SEL: assert property (@(posedge mclk) disable iff (rst)
		(acc_space == EWG_SPACE_PROG && !wait_state_ranges_reg[15] && !acc_addr[15]
		&& !wait_double_bit_reg)
		|-> waits_next == {1'b0, wait_state_ranges_reg[2:0]})
		else $error("Lower program count not from its field.");
endmodule : ewg_wait_gen

// ===== logic/ewg_pkg.sv
// Package with register map, field layout, reset values and timing for the wait-state generator.
// Behaviour
// - Software wait states stretch any external bus cycle, up to fourteen cycles.
// - Slow devices lengthen cycles further with ready; the generator honours ready.
// - All ranges at zero waits gate off the generator's internal clock enable.
// - Low fifteen bits hold five 3-bit base counts, one per range.
// - Every base count is scaled by one or two per the double bit.
// - Reset loads 111 into every range field: seven waits everywhere.
// - Bit 15 is read/write range select, reset zero, remapping program fields.
// - Bits 14..12 give waits for all I/O space accesses.
// - Bits 11..9 give waits for data addresses 8000..FFFF.
// - Bits 8..6 give waits for data addresses 0000..7FFF.
// - Bits 5..3 serve program offsets 8000..FFFF when select is zero only.
// - Bits 2..0 serve program offsets 0000..7FFF, or everything when select is one.
// - Double bit is bit 0 of scale register, reset zero; one doubles counts.
// - Scale register bits 15..1 read zero and ignore writes.
package ewg_pkg;
	localparam logic [15:0] EWG_WSR_ADDR    = 16'h0028;
	localparam logic [15:0] EWG_SCR_ADDR    = 16'h002b;
	localparam logic [15:0] EWG_WSR_RESET   = 16'h7fff;
	localparam logic [15:0] EWG_SCR_RESET   = 16'h0000;
	localparam int          EWG_SEL_BIT     = 15;
	localparam int          EWG_IO_LSB      = 12;
	localparam int          EWG_DHI_LSB     = 9;
	localparam int          EWG_DLO_LSB     = 6;
	localparam int          EWG_PHI_LSB     = 3;
	localparam int          EWG_PLO_LSB     = 0;
	localparam int          EWG_DBL_BIT     = 0;
	localparam int          EWG_HALF_BIT    = 15;
	localparam logic [3:0]  EWG_MAX_WAITS   = 4'he;
	localparam logic [1:0]  EWG_SPACE_PROG  = 2'h0;
	localparam logic [1:0]  EWG_SPACE_DATA  = 2'h1;
	localparam logic [1:0]  EWG_SPACE_IO    = 2'h2;
	typedef enum logic [2:0] {
		EWG_IDLE = 3'b001,
		EWG_WAIT = 3'b010,
		EWG_RDY  = 3'b100
	} ewg_state_t;
endpackage : ewg_pkg

// ===== tb/ewg_ready_model.sv
// Model of a slow external device that drives the ready pin.
`timescale 1ns/10ps
module ewg_ready_model (
	input  wire logic       mclk,
	input  wire logic       acc_busy,
	input  wire logic [7:0] hold_cycles,
	output logic            ready
);
	logic [7:0] cnt_reg;

	// Holds ready low for hold_cycles of each bus cycle; zero answers at once.
	always_ff @(posedge mclk) begin
		if (!acc_busy)
			cnt_reg <= hold_cycles;
		else if (cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
	end
	assign ready = !(acc_busy && cnt_reg != 8'h00);
endmodule : ewg_ready_model

// ===== tb/tb_ewg_wait_gen.sv
// Self-checking testbench for the wait-state generator.
`timescale 1ns/10ps
module tb_ewg_wait_gen;
	import ewg_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic        acc_start = 1'b0;
	logic [1:0]  acc_space = 2'h0;
	logic [15:0] acc_addr = 16'h0000;
	logic        ready;
	logic        acc_done;
	logic        acc_busy;
	logic        wait_clk_on;
	logic [7:0]  hold_cycles = 8'h00;
	int          errors = 0;
	int          compares = 0;

	ewg_wait_gen ewg_wait_gen_i (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.acc_start(acc_start), .acc_space(acc_space), .acc_addr(acc_addr), .ready(ready),
		.acc_done(acc_done), .acc_busy(acc_busy), .wait_clk_on(wait_clk_on));
	ewg_ready_model ewg_ready_model_i (.mclk(mclk), .acc_busy(acc_busy),
		.hold_cycles(hold_cycles), .ready(ready));

	// Free-running machine clock, 20 ns period.
	always #10 mclk = ~mclk;

	task automatic end_of_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd_chk

	// Counts edges after the taking edge until done is seen, so w waits give w plus one.
	// Busy must stand for the whole cycle and drop with done; a hang ends the run.
	task automatic acc(input logic [1:0] sp, input logic [15:0] a, output int n);
		@(posedge mclk);
		acc_start <= 1'b1;
		acc_space <= sp;
		acc_addr <= a;
		@(posedge mclk);
		acc_start <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
			if (acc_done !== 1'b1) begin
				chk(16'(acc_busy), 16'h0001);
			end
			if (n > 500) begin
				errors++;
				end_of_test();
			end
		end while (acc_done !== 1'b1);
		chk(16'(acc_busy), 16'h0000);
	endtask : acc

	task automatic acc_chk(input logic [1:0] sp, input logic [15:0] a, input int w);
		int n;
		acc(sp, a, n);
		chk(16'(n), 16'(w + 1));
	endtask : acc_chk

	task automatic t_regs;
		rd_chk(EWG_WSR_ADDR, 16'h7fff);
		rd_chk(EWG_SCR_ADDR, 16'h0000);
		rd_chk(16'h0030, 16'h0000);
		acc_chk(2'h1, 16'h1234, 7);
		$display("test regs done");
	endtask : t_regs

	task automatic t_fields;
		wr(EWG_WSR_ADDR, 16'h14e5);
		acc_chk(2'h2, 16'hffff, 1);
		acc_chk(2'h1, 16'h8000, 2);
		acc_chk(2'h1, 16'h7fff, 3);
		acc_chk(2'h0, 16'h8000, 4);
		acc_chk(2'h0, 16'h7fff, 5);
		acc_chk(2'h3, 16'h8000, 4);
		wr(EWG_WSR_ADDR, 16'h94e5);
		rd_chk(EWG_WSR_ADDR, 16'h94e5);
		acc_chk(2'h0, 16'h8000, 5);
		$display("test fields done");
	endtask : t_fields

	task automatic t_double;
		wr(EWG_SCR_ADDR, 16'hffff);
		rd_chk(EWG_SCR_ADDR, 16'h0001);
		acc_chk(2'h2, 16'h0000, 2);
		wr(EWG_WSR_ADDR, 16'h7fff);
		acc_chk(2'h1, 16'h0000, 14);
		wr(EWG_SCR_ADDR, 16'h0000);
		$display("test double done");
	endtask : t_double

	task automatic t_ready;
		int n;
		hold_cycles <= 8'd20;
		acc(2'h1, 16'h0000, n);
		chk(16'(n > 21 && n < 30), 16'h0001);
		hold_cycles <= 8'd0;
		$display("test ready done");
	endtask : t_ready

	task automatic t_zero;
		wr(EWG_WSR_ADDR, 16'h0000);
		@(posedge mclk);
		#1;
		chk(16'(wait_clk_on), 16'h0000);
		acc_chk(2'h0, 16'h0000, 0);
		wr(EWG_WSR_ADDR, 16'h0008);
		@(posedge mclk);
		#1;
		chk(16'(wait_clk_on), 16'h0001);
		$display("test zero done");
	endtask : t_zero

	// Reset in mid-run must bring back seven waits everywhere and a cleared double bit.
	task automatic t_reset;
		wr(EWG_WSR_ADDR, 16'h9249);
		wr(EWG_SCR_ADDR, 16'h0001);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd_chk(EWG_WSR_ADDR, 16'h7fff);
		rd_chk(EWG_SCR_ADDR, 16'h0000);
		acc_chk(2'h2, 16'h0000, 7);
		$display("test reset done");
	endtask : t_reset

	// Main sequence: reset for ten cycles, then each scenario in turn.
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_fields();
		t_double();
		t_ready();
		t_zero();
		t_reset();
		end_of_test();
	end
endmodule : tb_ewg_wait_gen
